/* ppc_regs.svh */
// register offsets, implemented-bit masks, reset values and timing for the pin config bank
// assumes a 16-bit byte address space and 8-bit register data
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

`define PPC_ADDR_W        16
`define PPC_DATA_W        8

`define PPC_OFS_DRIVE6    16'hff2a
`define PPC_OFS_ANALOG2   16'hff2e
`define PPC_OFS_ANALOG7   16'hff2f
`define PPC_OFS_PULLUP0   16'hff30
`define PPC_OFS_PULLUP3   16'hff33
`define PPC_OFS_PULLUP6   16'hff36
`define PPC_OFS_INBUF6    16'hff3a

`define PPC_MASK_DRIVE6   8'h03
`define PPC_MASK_ANALOG2  8'hff
`define PPC_MASK_ANALOG7  8'h01
`define PPC_MASK_PULLUP0  8'h07
`define PPC_MASK_PULLUP3  8'hff
`define PPC_MASK_PULLUP6  8'h03
`define PPC_MASK_INBUF6   8'h03

`define PPC_RESET_VAL     8'h00
`define PPC_WAIT_CYCLES   1

`define PPC_NUM_PULLUP    13

`endif

/* ppc_pkg.sv */
// types shared by the pin config bank
// assumes ppc_regs.svh supplies the numeric constants
package ppc_pkg;

  typedef enum logic [2:0] {
    PPC_SEL_NONE    = 3'b000,
    PPC_SEL_DRIVE6  = 3'b001,
    PPC_SEL_ANALOG2 = 3'b010,
    PPC_SEL_ANALOG7 = 3'b011,
    PPC_SEL_PULLUP0 = 3'b100,
    PPC_SEL_PULLUP3 = 3'b101,
    PPC_SEL_PULLUP6 = 3'b110,
    PPC_SEL_INBUF6  = 3'b111
  } ppc_sel_t;

  typedef logic [7:0] ppc_byte_t;

endpackage

/* ppc_top.sv */
// pin configuration register bank: pull-ups, port 6 buffer/driver mode, analog select
// assumes a single-cycle strobe master on ref_clk; pin direction inputs are synchronous
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"

module ppc_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic [7:0]  bus_wmask,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  output logic             cpu_wait,
  input  wire logic [2:0]  port0_is_input,
  input  wire logic [2:0]  port0_alt_out,
  input  wire logic [7:0]  port3_is_input,
  input  wire logic [7:0]  port3_alt_out,
  input  wire logic [1:0]  port6_is_input,
  input  wire logic [1:0]  port6_alt_out,
  output logic      [2:0]  port0_pullup_en,
  output logic      [7:0]  port3_pullup_en,
  output logic      [1:0]  port6_pullup_en,
  output logic      [1:0]  port6_smbus_buf,
  output logic      [1:0]  port6_open_drain,
  output logic      [7:0]  port2_digital,
  output logic             port7_pin0_digital,
  input  wire logic        osc_mode_active,
  input  wire logic [1:0]  osc_latch_raw,
  output logic      [1:0]  osc_latch_read
);

  // reset release through two flops
  // the whole bank leaves reset on one clock edge, never mid-cycle
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // address decode, used by both the write and the read path
  function automatic ppc_pkg::ppc_sel_t ppc_decode(input logic [15:0] addr);
    ppc_pkg::ppc_sel_t sel;
    begin
      case (addr)
        `PPC_OFS_DRIVE6:  sel = ppc_pkg::PPC_SEL_DRIVE6;
        `PPC_OFS_ANALOG2: sel = ppc_pkg::PPC_SEL_ANALOG2;
        `PPC_OFS_ANALOG7: sel = ppc_pkg::PPC_SEL_ANALOG7;
        `PPC_OFS_PULLUP0: sel = ppc_pkg::PPC_SEL_PULLUP0;
        `PPC_OFS_PULLUP3: sel = ppc_pkg::PPC_SEL_PULLUP3;
        `PPC_OFS_PULLUP6: sel = ppc_pkg::PPC_SEL_PULLUP6;
        `PPC_OFS_INBUF6:  sel = ppc_pkg::PPC_SEL_INBUF6;
        default:          sel = ppc_pkg::PPC_SEL_NONE;
      endcase
      ppc_decode = sel;
    end
  endfunction

  // masked merge: only lanes in the write mask change, only implemented bits kept
  // a single-bit write is a one-hot mask, a byte write is all ones
  function automatic ppc_pkg::ppc_byte_t ppc_merge(input ppc_pkg::ppc_byte_t cur,
                                                   input ppc_pkg::ppc_byte_t wdata,
                                                   input ppc_pkg::ppc_byte_t wmask,
                                                   input ppc_pkg::ppc_byte_t impl);
    begin
      ppc_merge = ((cur & ~wmask) | (wdata & wmask)) & impl;
    end
  endfunction

  ppc_pkg::ppc_sel_t wr_sel;
  ppc_pkg::ppc_sel_t rd_sel;

  // one decode serves both strobes; the master never raises both at once
  assign wr_sel = ppc_decode(bus_addr);
  assign rd_sel = ppc_decode(bus_addr);

  // configuration registers
  // widest variant: eight port 2 pins and the port 7 pin are present
  ppc_pkg::ppc_byte_t drive6_q;
  ppc_pkg::ppc_byte_t drive6_d;

  ppc_pkg::ppc_byte_t analog2_q;
  ppc_pkg::ppc_byte_t analog2_d;

  ppc_pkg::ppc_byte_t analog7_q;
  ppc_pkg::ppc_byte_t analog7_d;

  ppc_pkg::ppc_byte_t pullup0_q;
  ppc_pkg::ppc_byte_t pullup0_d;

  ppc_pkg::ppc_byte_t pullup3_q;
  ppc_pkg::ppc_byte_t pullup3_d;

  ppc_pkg::ppc_byte_t pullup6_q;
  ppc_pkg::ppc_byte_t pullup6_d;

  ppc_pkg::ppc_byte_t inbuf6_q;
  ppc_pkg::ppc_byte_t inbuf6_d;

  always_comb begin
    drive6_d  = drive6_q;
    analog2_d = analog2_q;
    analog7_d = analog7_q;
    pullup0_d = pullup0_q;
    pullup3_d = pullup3_q;
    pullup6_d = pullup6_q;
    inbuf6_d  = inbuf6_q;
    if (bus_wr) begin
      // the mask carries either one bit or the whole byte
      case (wr_sel)
        ppc_pkg::PPC_SEL_DRIVE6: begin
          drive6_d = ppc_merge(drive6_q, bus_wdata, bus_wmask, `PPC_MASK_DRIVE6);
        end
        ppc_pkg::PPC_SEL_ANALOG2: begin
          analog2_d = ppc_merge(analog2_q, bus_wdata, bus_wmask, `PPC_MASK_ANALOG2);
        end
        ppc_pkg::PPC_SEL_ANALOG7: begin
          analog7_d = ppc_merge(analog7_q, bus_wdata, bus_wmask, `PPC_MASK_ANALOG7);
        end
        ppc_pkg::PPC_SEL_PULLUP0: begin
          pullup0_d = ppc_merge(pullup0_q, bus_wdata, bus_wmask, `PPC_MASK_PULLUP0);
        end
        ppc_pkg::PPC_SEL_PULLUP3: begin
          pullup3_d = ppc_merge(pullup3_q, bus_wdata, bus_wmask, `PPC_MASK_PULLUP3);
        end
        ppc_pkg::PPC_SEL_PULLUP6: begin
          pullup6_d = ppc_merge(pullup6_q, bus_wdata, bus_wmask, `PPC_MASK_PULLUP6);
        end
        ppc_pkg::PPC_SEL_INBUF6: begin
          inbuf6_d = ppc_merge(inbuf6_q, bus_wdata, bus_wmask, `PPC_MASK_INBUF6);
        end
        default: begin
        end
      endcase
    end
  end

  // every select clears together, so all pins start analog with no pull-up
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pullup0_q <= `PPC_RESET_VAL;
      pullup3_q <= `PPC_RESET_VAL;
      pullup6_q <= `PPC_RESET_VAL;
      drive6_q  <= `PPC_RESET_VAL;
      inbuf6_q  <= `PPC_RESET_VAL;
      analog2_q <= `PPC_RESET_VAL;
      analog7_q <= `PPC_RESET_VAL;
    end else begin
      pullup0_q <= pullup0_d;
      pullup3_q <= pullup3_d;
      pullup6_q <= pullup6_d;
      drive6_q  <= drive6_d;
      inbuf6_q  <= inbuf6_d;
      analog2_q <= analog2_d;
      analog7_q <= analog7_d;
    end
  end

  // read path: data stand only in the cycle after the strobe
  // idle cycles and unmapped offsets read back zero
  ppc_pkg::ppc_byte_t rdata_q;
  ppc_pkg::ppc_byte_t rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (bus_rd) begin
      case (rd_sel)
        ppc_pkg::PPC_SEL_DRIVE6:  rdata_d = drive6_q;
        ppc_pkg::PPC_SEL_ANALOG2: rdata_d = analog2_q;
        ppc_pkg::PPC_SEL_ANALOG7: rdata_d = analog7_q;
        ppc_pkg::PPC_SEL_PULLUP0: rdata_d = pullup0_q;
        ppc_pkg::PPC_SEL_PULLUP3: rdata_d = pullup3_q;
        ppc_pkg::PPC_SEL_PULLUP6: rdata_d = pullup6_q;
        ppc_pkg::PPC_SEL_INBUF6:  rdata_d = inbuf6_q;
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // wait request after an analog select write
  // the flag only tells the cpu; this bank never holds back a transfer
  logic wait_q;
  logic wait_d;

  always_comb begin
    wait_d = 1'b0;
    // port 7 select writes take the same wait cycle as port 2
    if (bus_wr && (wr_sel == ppc_pkg::PPC_SEL_ANALOG2 ||
                   wr_sel == ppc_pkg::PPC_SEL_ANALOG7)) begin
      wait_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
    end
  end

  // pull-up gating per pin
  logic [`PPC_NUM_PULLUP-1:0] pu_sel;
  logic [`PPC_NUM_PULLUP-1:0] pu_in;
  logic [`PPC_NUM_PULLUP-1:0] pu_alt;
  logic [`PPC_NUM_PULLUP-1:0] pu_en_d;
  logic [`PPC_NUM_PULLUP-1:0] pu_en_q;

  // vector order: port 0 in the low bits, then port 3, then port 6
  assign pu_sel = {pullup6_q[1:0], pullup3_q[7:0], pullup0_q[2:0]};
  assign pu_in  = {port6_is_input, port3_is_input, port0_is_input};
  assign pu_alt = {port6_alt_out, port3_alt_out, port0_alt_out};

  // one gate per pin keeps each resistor independent
  genvar gi;
  generate
    for (gi = 0; gi < `PPC_NUM_PULLUP; gi = gi + 1) begin : g_pullup
      // bit 1 connects, and only on a plain input pin
      assign pu_en_d[gi] = pu_sel[gi] & pu_in[gi] & ~pu_alt[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pu_en_q <= '0;
    end else begin
      pu_en_q <= pu_en_d;
    end
  end

  // oscillator pin latch read-back
  // the raw latch is masked while the pins carry the main oscillator
  logic [1:0] osc_rd_q;
  logic [1:0] osc_rd_d;

  always_comb begin
    osc_rd_d = osc_mode_active ? 2'b00 : osc_latch_raw;
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      osc_rd_q <= 2'b00;
    end else begin
      osc_rd_q <= osc_rd_d;
    end
  end

  // every output is a register copy; no decode logic reaches a pin
  assign bus_rdata          = rdata_q;
  assign cpu_wait           = wait_q;
  assign port0_pullup_en    = pu_en_q[2:0];
  assign port3_pullup_en    = pu_en_q[10:3];
  assign port6_pullup_en    = pu_en_q[12:11];
  assign port6_smbus_buf    = inbuf6_q[1:0];
  assign port6_open_drain   = drive6_q[1:0];
  assign port2_digital      = analog2_q;
  assign port7_pin0_digital = analog7_q[0];
  assign osc_latch_read     = osc_rd_q;

endmodule

`default_nettype wire

/* ppc_top_chk.sv */
// concurrent checks on the pin config bank ports
// assumes ppc_regs.svh offsets and one-cycle read data
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"
module ppc_top_chk (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_wmask,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_rdata,
  input wire logic        cpu_wait,
  input wire logic [2:0]  port0_is_input,
  input wire logic [2:0]  port0_alt_out,
  input wire logic [2:0]  port0_pullup_en,
  input wire logic [7:0]  port3_is_input,
  input wire logic [7:0]  port3_alt_out,
  input wire logic [7:0]  port3_pullup_en,
  input wire logic [1:0]  port6_is_input,
  input wire logic [1:0]  port6_alt_out,
  input wire logic [1:0]  port6_pullup_en,
  input wire logic [1:0]  port6_open_drain,
  input wire logic [7:0]  port2_digital,
  input wire logic        osc_mode_active,
  input wire logic [1:0]  osc_latch_read
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence wr_an2;
    bus_wr && bus_addr == `PPC_OFS_ANALOG2;
  endsequence
  sequence wr_an7;
    bus_wr && bus_addr == `PPC_OFS_ANALOG7;
  endsequence
  sequence wr_drv_byte;
    bus_wr && bus_addr == `PPC_OFS_DRIVE6 && bus_wmask == 8'hff;
  endsequence
  AST_PU0_GATE: assert property (
    (port0_pullup_en & ~($past(port0_is_input) & ~$past(port0_alt_out))) == 3'h0)
    else $error("port0 pull-up on for a non-input pin");
  AST_PU3_GATE: assert property (
    (port3_pullup_en & ~($past(port3_is_input) & ~$past(port3_alt_out))) == 8'h00)
    else $error("port3 pull-up on for a non-input pin");
  AST_PU6_GATE: assert property (
    (port6_pullup_en & ~($past(port6_is_input) & ~$past(port6_alt_out))) == 2'h0)
    else $error("port6 pull-up on for a non-input pin");
  AST_WAIT_ON: assert property (
    wr_an2 ##1 !bus_wr |-> cpu_wait ##1 !cpu_wait)
    else $error("no single wait pulse after analog write");
  AST_WAIT_SET: assert property (
    wr_an2 |=> cpu_wait)
    else $error("no wait after port2 analog write");
  AST_WAIT_AN7: assert property (
    wr_an7 |=> cpu_wait)
    else $error("no wait after port7 analog write");
  AST_WAIT_CAUSE: assert property (
    cpu_wait |-> $past(bus_wr) && ($past(bus_addr) == `PPC_OFS_ANALOG2 ||
                                   $past(bus_addr) == `PPC_OFS_ANALOG7))
    else $error("wait pulse without analog write");
  AST_RD_IDLE: assert property (
    !$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_DRV_WR: assert property (
    wr_drv_byte |=> port6_open_drain == $past(bus_wdata[1:0]))
    else $error("drive mode not written");
  AST_PU0_UNIMP: assert property (
    $past(bus_rd) && $past(bus_addr) == `PPC_OFS_PULLUP0 |-> bus_rdata[7:3] == 5'h00)
    else $error("unimplemented bits read nonzero");
  AST_AN2_HOLD: assert property (
    !($past(bus_wr) && $past(bus_addr) == `PPC_OFS_ANALOG2) |-> $stable(port2_digital))
    else $error("analog select changed without write");
  AST_OSC_ZERO: assert property (
    $past(osc_mode_active) |-> osc_latch_read == 2'h0)
    else $error("oscillator latch not zero");
endmodule
bind ppc_top ppc_top_chk u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wmask(bus_wmask), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .cpu_wait(cpu_wait), .port0_is_input(port0_is_input), .port0_alt_out(port0_alt_out),
  .port0_pullup_en(port0_pullup_en), .port3_is_input(port3_is_input),
  .port3_alt_out(port3_alt_out), .port3_pullup_en(port3_pullup_en),
  .port6_is_input(port6_is_input), .port6_alt_out(port6_alt_out),
  .port6_pullup_en(port6_pullup_en), .port6_open_drain(port6_open_drain),
  .port2_digital(port2_digital), .osc_mode_active(osc_mode_active),
  .osc_latch_read(osc_latch_read)
);
`default_nettype wire

/* ppc_top_tb.sv */
// bench for the pin config bank: register access, pull-up gating, oscillator latch
// assumes ppc_top and its checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"
module ppc_top_tb;
  logic        ref_clk = 1'b0, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic        osc_mode_active = 1'b0;
  logic        cpu_wait, port7_pin0_digital;
  logic [15:0] bus_addr = '0;
  logic [7:0]  bus_wdata = '0, bus_wmask = '0, bus_rdata;
  logic [7:0]  port3_is_input = '0, port3_alt_out = '0;
  logic [7:0]  port3_pullup_en, port2_digital;
  logic [2:0]  port0_is_input = '0, port0_alt_out = '0, port0_pullup_en;
  logic [1:0]  port6_is_input = '0, port6_alt_out = '0, port6_pullup_en, port6_smbus_buf;
  logic [1:0]  port6_open_drain, osc_latch_raw = '0, osc_latch_read;
  int          errors = 0, n_compared = 0, cyc = 0;
  logic [15:0] adr [7] = '{`PPC_OFS_DRIVE6, `PPC_OFS_ANALOG2, `PPC_OFS_ANALOG7,
    `PPC_OFS_PULLUP0, `PPC_OFS_PULLUP3, `PPC_OFS_PULLUP6, `PPC_OFS_INBUF6};
  logic [7:0]  msk [7] = '{`PPC_MASK_DRIVE6, `PPC_MASK_ANALOG2, `PPC_MASK_ANALOG7,
    `PPC_MASK_PULLUP0, `PPC_MASK_PULLUP3, `PPC_MASK_PULLUP6, `PPC_MASK_INBUF6};
  ppc_top uut (
    .ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wmask(bus_wmask), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .cpu_wait(cpu_wait), .port0_is_input(port0_is_input), .port0_alt_out(port0_alt_out),
    .port3_is_input(port3_is_input), .port3_alt_out(port3_alt_out),
    .port6_is_input(port6_is_input), .port6_alt_out(port6_alt_out),
    .port0_pullup_en(port0_pullup_en), .port3_pullup_en(port3_pullup_en),
    .port6_pullup_en(port6_pullup_en), .port6_smbus_buf(port6_smbus_buf),
    .port6_open_drain(port6_open_drain), .port2_digital(port2_digital),
    .port7_pin0_digital(port7_pin0_digital), .osc_mode_active(osc_mode_active),
    .osc_latch_raw(osc_latch_raw), .osc_latch_read(osc_latch_read)
  );
  initial forever #5 ref_clk = ~ref_clk;
  task automatic final_report;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      final_report;
    end
  end
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d, logic [7:0] m);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wmask <= m;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [7:0] e, string nm);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 chk(nm, e, bus_rdata);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 7; i++) rd(adr[i], 8'h00, "reset value");
    for (int i = 0; i < 7; i++) begin
      wr(adr[i], 8'hff, 8'hff);
      rd(adr[i], msk[i], "byte readback");
    end
    chk("open drain", 8'h03, {6'h0, port6_open_drain});
    chk("smbus buffer", 8'h03, {6'h0, port6_smbus_buf});
    chk("port7 digital", 8'h01, {7'h0, port7_pin0_digital});
    wr(`PPC_OFS_DRIVE6, 8'h00, 8'h01);
    #1 chk("drive bit0 cleared", 8'h02, {6'h0, port6_open_drain});
    wr(`PPC_OFS_ANALOG2, 8'h5a, 8'hff);
    #1 chk("wait pulse", 8'h01, {7'h0, cpu_wait});
    chk("port2 digital", 8'h5a, port2_digital);
    @(posedge ref_clk);
    #1 chk("wait end", 8'h00, {7'h0, cpu_wait});
    @(posedge ref_clk);
    port0_is_input <= 3'b011;
    port0_alt_out <= 3'b010;
    port3_is_input <= 8'hf0;
    port3_alt_out <= 8'h3c;
    port6_is_input <= 2'b11;
    repeat (2) @(posedge ref_clk);
    #1 chk("pullup0", 8'h01, {5'h0, port0_pullup_en});
    chk("pullup3", 8'hc0, port3_pullup_en);
    wr(`PPC_OFS_PULLUP6, 8'h00, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1 chk("pullup6", 8'h01, {6'h0, port6_pullup_en});
    wr(`PPC_OFS_PULLUP3, 8'h00, 8'h08);
    rd(`PPC_OFS_PULLUP3, 8'hf7, "bit write");
    @(posedge ref_clk);
    osc_mode_active <= 1'b1;
    osc_latch_raw <= 2'b11;
    repeat (2) @(posedge ref_clk);
    #1 chk("osc latch", 8'h00, {6'h0, osc_latch_read});
    @(posedge ref_clk);
    osc_mode_active <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("osc latch raw", 8'h03, {6'h0, osc_latch_read});
    wr(16'hff31, 8'hff, 8'hff);
    rd(16'hff31, 8'h00, "unmapped");
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    #1 chk("port2 in reset", 8'h00, port2_digital);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(`PPC_OFS_DRIVE6, 8'h00, "drive after reset");
    rd(`PPC_OFS_PULLUP0, 8'h00, "pullup after reset");
    final_report;
  end
endmodule
`default_nettype wire
